// ---- logic/sarseq_pkg.sv ----
package sarseq_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam int              ADDR_W         = 8;
  localparam logic [7:0]      OFS_TIMING     = 8'h00;
  localparam logic [7:0]      OFS_SEQUENCE   = 8'h04;
  localparam logic [7:0]      OFS_STATUS     = 8'h08;
  localparam logic [7:0]      OFS_RESULT     = 8'h20;
  localparam logic [7:0]      OFS_RESULT_MSK = 8'hE0;

  // AXI response codes.
  localparam logic [1:0]      RESP_OKAY      = 2'h0;
  localparam logic [1:0]      RESP_SLVERR    = 2'h2;

  // Reset values of the timing fields.
  localparam logic [4:0]      RST_CLK_DIV    = 5'h03;
  localparam logic [1:0]      RST_SAMPLE_EXT = 2'h0;
  localparam logic            RST_TEN_BIT    = 1'b0;

  // Smallest valid divider code, used in place of the reserved one.
  localparam logic [4:0]      DIV_RESERVED   = 5'h00;
  localparam logic [4:0]      DIV_MIN_VALID  = 5'h01;

  // Sample period shape in converter clocks.
  localparam logic [4:0]      PH1_END        = 5'h02;
  localparam logic [4:0]      PH2_END        = 5'h04;
  localparam logic [4:0]      DIRECT_BASE    = 5'h02;

  // Most significant bit index for each resolution.
  localparam logic [3:0]      MSB_TEN        = 4'h9;
  localparam logic [3:0]      MSB_EIGHT      = 4'h7;

  // Conversions per sequence, minus one.
  localparam logic [2:0]      LAST_FOUR      = 3'h3;
  localparam logic [2:0]      LAST_EIGHT     = 3'h7;

  // Reserved channel codes.
  localparam logic [3:0]      CH_RSV_LO      = 4'h8;
  localparam logic [3:0]      CH_RSV_HI      = 4'hB;

  typedef struct packed {
    logic       ten_bit;
    logic [1:0] sample_ext;
    logic [4:0] clk_div;
  } sarseq_timing_s;

  typedef struct packed {
    logic       eight_conv;
    logic       repeat_sel;
    logic       multi;
    logic [3:0] chan;
  } sarseq_seq_s;

  typedef struct packed {
    logic       seq_done;
    logic       busy;
    logic [2:0] mode;
    logic [2:0] conv_ptr;
    logic [7:0] conv_done;
  } sarseq_status_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } sarseq_state_e;

endpackage : sarseq_pkg

// ---- logic/sarseq_prescaler.sv ----
`timescale 1ns/1ns
module sarseq_prescaler (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [4:0] i_div,
  input  wire logic       i_clear,
  output logic            o_tick
);

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       half_r;
  logic       half_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic [4:0] div_eff;
  logic       stage;

  // First stage divides by the code plus one (code 0 as code 1), second stage by two.
  always_comb
  begin
    div_eff  = (i_div == sarseq_pkg::DIV_RESERVED) ? sarseq_pkg::DIV_MIN_VALID : i_div;
    stage    = (cnt_r == div_eff);
    cnt_nxt  = stage ? 5'h00 : 5'(cnt_r + 5'h01);
    half_nxt = stage ? ~half_r : half_r;
    tick_nxt = stage & half_r;
    // A restart starts one count in, so the first sample phase is not a cycle longer.
    if (i_clear)
    begin
      cnt_nxt  = 5'h01;
      half_nxt = 1'b0;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r  <= 5'h00;
      half_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      half_r <= half_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;

endmodule : sarseq_prescaler

// ---- logic/sarseq_top.sv ----
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module sarseq_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_comp_higher,
  output logic [3:0]       o_mux_sel,
  output logic             o_mux_en,
  output logic             o_mux_to_cap,
  output logic             o_buf_to_array,
  output logic             o_direct_to_array,
  output logic [9:0]       o_dac_code
);

  sarseq_pkg::sarseq_timing_s tim_r;
  sarseq_pkg::sarseq_timing_s tim_nxt;
  sarseq_pkg::sarseq_seq_s    seq_r;
  sarseq_pkg::sarseq_seq_s    seq_nxt;
  sarseq_pkg::sarseq_state_e  state_r;
  sarseq_pkg::sarseq_state_e  state_nxt;
  sarseq_pkg::sarseq_status_s stat;
  logic [4:0]  samp_r;
  logic [4:0]  samp_nxt;
  logic [3:0]  bit_r;
  logic [3:0]  bit_nxt;
  logic [9:0]  sar_r;
  logic [9:0]  sar_nxt;
  logic [2:0]  idx_r;
  logic [2:0]  idx_nxt;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic        sdone_r;
  logic        sdone_nxt;
  logic [9:0]  res_r   [8];
  logic [9:0]  res_nxt [8];
  logic [9:0]  final_val;
  logic [4:0]  samp_last;
  logic [3:0]  msb;
  logic [2:0]  last_idx;
  logic [3:0]  chan_cur;
  logic        conv_done;
  logic        tick;
  logic        comp_s1_r;
  logic        comp_s2_r;
  logic        aw_full_r;
  logic        aw_full_nxt;
  logic        w_full_r;
  logic        w_full_nxt;
  logic [7:0]  awaddr_r;
  logic [7:0]  awaddr_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic        wstrb0_r;
  logic        wstrb0_nxt;
  logic        bvalid_nxt;
  logic [1:0]  bresp_nxt;
  logic        rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt;
  logic        awready_nxt;
  logic        wready_nxt;
  logic        arready_nxt;
  logic        wr_fire;
  logic        wr_tim;
  logic        wr_seq;
  logic        mux_en_nxt;
  logic        cap_nxt;
  logic        buf_nxt;
  logic        dir_nxt;

  sarseq_prescaler u_prescaler (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_div   (tim_r.clk_div),
    .i_clear (wr_tim | wr_seq),
    .o_tick  (tick)
  );

  // Comparator decision comes from the analog side, so it is synchronised.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
    end
    else
    begin
      comp_s1_r <= i_comp_higher;
      comp_s2_r <= comp_s1_r;
    end
  end

  // AXI4-Lite slave: address and data are caught in either order, then written.
  always_comb
  begin
    wr_fire     = aw_full_r & w_full_r & ~o_bvalid;
    wr_tim      = wr_fire & (awaddr_r == sarseq_pkg::OFS_TIMING);
    wr_seq      = wr_fire & (awaddr_r == sarseq_pkg::OFS_SEQUENCE);
    aw_full_nxt = aw_full_r;
    w_full_nxt  = w_full_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = o_bvalid & ~i_bready;
    bresp_nxt   = o_bresp;
    if (i_awvalid & o_awready)
    begin
      aw_full_nxt = 1'b1;
      awaddr_nxt  = {i_awaddr[7:2], 2'h0};
    end
    if (i_wvalid & o_wready)
    begin
      w_full_nxt = 1'b1;
      wdata_nxt  = i_wdata;
      wstrb0_nxt = i_wstrb[0];
    end
    if (wr_fire)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wr_tim | wr_seq) ? sarseq_pkg::RESP_OKAY : sarseq_pkg::RESP_SLVERR;
    end
    awready_nxt = ~aw_full_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_full_nxt & ~bvalid_nxt;
    rvalid_nxt  = o_rvalid & ~i_rready;
    rdata_nxt   = o_rdata;
    rresp_nxt   = o_rresp;
    if (i_arvalid & o_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = sarseq_pkg::RESP_OKAY;
      if ({i_araddr[7:2], 2'h0} == sarseq_pkg::OFS_TIMING)
        rdata_nxt = {24'h000000, tim_r};
      else if ({i_araddr[7:2], 2'h0} == sarseq_pkg::OFS_SEQUENCE)
        rdata_nxt = {25'h0000000, seq_r};
      else if ({i_araddr[7:2], 2'h0} == sarseq_pkg::OFS_STATUS)
        rdata_nxt = {16'h0000, stat};
      else if ((i_araddr & sarseq_pkg::OFS_RESULT_MSK) == sarseq_pkg::OFS_RESULT)
        rdata_nxt = {22'h000000, res_r[i_araddr[4:2]]};
      else
      begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = sarseq_pkg::RESP_SLVERR;
      end
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb0_r  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= 2'h0;
      o_arready <= 1'b0;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      o_bvalid  <= bvalid_nxt;
      o_bresp   <= bresp_nxt;
      o_awready <= awready_nxt;
      o_wready  <= wready_nxt;
      o_rvalid  <= rvalid_nxt;
      o_rdata   <= rdata_nxt;
      o_rresp   <= rresp_nxt;
      o_arready <= arready_nxt;
    end
  end

  // Sequencer: sample phases, successive approximation and result storage.
  always_comb
  begin
    msb       = tim_r.ten_bit ? sarseq_pkg::MSB_TEN : sarseq_pkg::MSB_EIGHT;
    last_idx  = seq_r.eight_conv ? sarseq_pkg::LAST_EIGHT : sarseq_pkg::LAST_FOUR;
    samp_last = 5'((sarseq_pkg::DIRECT_BASE << tim_r.sample_ext) + sarseq_pkg::PH2_END - 5'h01);
    conv_done = (state_r == sarseq_pkg::ST_CONVERT) & tick & (bit_r == 4'h0);
    final_val = comp_s2_r ? (sar_r & ~(10'h001 << bit_r)) : sar_r;
    stat      = '{seq_done: sdone_r, busy: (state_r != sarseq_pkg::ST_IDLE),
                  mode: {seq_r.repeat_sel, seq_r.multi, seq_r.eight_conv},
                  conv_ptr: idx_r, conv_done: flags_r};
    tim_nxt   = tim_r;
    seq_nxt   = seq_r;
    state_nxt = state_r;
    samp_nxt  = samp_r;
    bit_nxt   = bit_r;
    sar_nxt   = sar_r;
    idx_nxt   = idx_r;
    flags_nxt = flags_r;
    sdone_nxt = sdone_r;
    for (int i = 0; i < 8; i++)
      res_nxt[i] = res_r[i];
    case (state_r)
      sarseq_pkg::ST_IDLE:
      begin
        state_nxt = sarseq_pkg::ST_IDLE;
      end
      sarseq_pkg::ST_SAMPLE:
      begin
        if (tick)
        begin
          samp_nxt = 5'(samp_r + 5'h01);
          if (samp_r == samp_last)
          begin
            state_nxt = sarseq_pkg::ST_CONVERT;
            bit_nxt   = msb;
            sar_nxt   = 10'h001 << msb;
          end
        end
      end
      sarseq_pkg::ST_CONVERT:
      begin
        if (tick)
        begin
          sar_nxt = final_val;
          if (bit_r != 4'h0)
          begin
            bit_nxt = 4'(bit_r - 4'h1);
            sar_nxt = final_val | (10'h001 << (bit_r - 4'h1));
          end
          else
          begin
            res_nxt[idx_r] = final_val;
            flags_nxt[idx_r] = 1'b1;
            samp_nxt = 5'h00;
            state_nxt = sarseq_pkg::ST_SAMPLE;
            idx_nxt = 3'(idx_r + 3'h1);
            if (idx_r == last_idx)
            begin
              sdone_nxt = 1'b1;
              idx_nxt   = 3'h0;
              if (!seq_r.repeat_sel)
                state_nxt = sarseq_pkg::ST_IDLE;
            end
          end
        end
      end
      default:
      begin
        state_nxt = sarseq_pkg::ST_IDLE;
      end
    endcase
    if (wr_tim)
    begin
      if (wstrb0_r)
        tim_nxt = sarseq_pkg::sarseq_timing_s'(wdata_r[7:0]);
      state_nxt = sarseq_pkg::ST_IDLE;
    end
    if (wr_seq)
    begin
      if (wstrb0_r)
        seq_nxt = sarseq_pkg::sarseq_seq_s'(wdata_r[6:0]);
      state_nxt = sarseq_pkg::ST_SAMPLE;
      samp_nxt  = 5'h00;
      idx_nxt   = 3'h0;
    end
    if ((wr_tim | wr_seq) & ((state_r != sarseq_pkg::ST_IDLE) | wr_seq))
    begin
      flags_nxt = 8'h00;
      sdone_nxt = 1'b0;
    end
    chan_cur   = seq_nxt.multi ? 4'(seq_nxt.chan + {1'b0, idx_nxt}) : seq_nxt.chan;
    mux_en_nxt = (state_nxt != sarseq_pkg::ST_IDLE) &
                 ~((chan_cur >= sarseq_pkg::CH_RSV_LO) & (chan_cur <= sarseq_pkg::CH_RSV_HI));
    cap_nxt    = (state_nxt == sarseq_pkg::ST_SAMPLE) & (samp_nxt < sarseq_pkg::PH1_END);
    buf_nxt    = (state_nxt == sarseq_pkg::ST_SAMPLE) & (samp_nxt >= sarseq_pkg::PH1_END) &
                 (samp_nxt < sarseq_pkg::PH2_END);
    dir_nxt    = (state_nxt == sarseq_pkg::ST_SAMPLE) & (samp_nxt >= sarseq_pkg::PH2_END);
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tim_r   <= '{ten_bit: sarseq_pkg::RST_TEN_BIT, sample_ext: sarseq_pkg::RST_SAMPLE_EXT,
                   clk_div: sarseq_pkg::RST_CLK_DIV};
      seq_r   <= '0;
      state_r <= sarseq_pkg::ST_IDLE;
      samp_r  <= 5'h00;
      bit_r   <= 4'h0;
      sar_r   <= 10'h000;
      idx_r   <= 3'h0;
      flags_r <= 8'h00;
      sdone_r <= 1'b0;
      for (int i = 0; i < 8; i++)
        res_r[i] <= 10'h000;
      o_mux_sel         <= 4'h0;
      o_mux_en          <= 1'b0;
      o_mux_to_cap      <= 1'b0;
      o_buf_to_array    <= 1'b0;
      o_direct_to_array <= 1'b0;
      o_dac_code        <= 10'h000;
    end
    else
    begin
      tim_r   <= tim_nxt;
      seq_r   <= seq_nxt;
      state_r <= state_nxt;
      samp_r  <= samp_nxt;
      bit_r   <= bit_nxt;
      sar_r   <= sar_nxt;
      idx_r   <= idx_nxt;
      flags_r <= flags_nxt;
      sdone_r <= sdone_nxt;
      for (int i = 0; i < 8; i++)
        res_r[i] <= res_nxt[i];
      o_mux_sel         <= chan_cur;
      o_mux_en          <= mux_en_nxt;
      o_mux_to_cap      <= cap_nxt;
      o_buf_to_array    <= buf_nxt;
      o_direct_to_array <= dir_nxt;
      o_dac_code        <= sar_nxt;
    end
  end

  sequence s_tick_gap;
    tick ##1 !tick [*3];
  endsequence

  sequence s_conv_end;
    conv_done & ~wr_fire;
  endsequence

  property p_tick_gap;
    @(posedge i_clk) disable iff (!i_rst_b) tick |-> s_tick_gap;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("Converter tick too close.");

  property p_abort_halt;
    @(posedge i_clk) disable iff (!i_rst_b) wr_tim |=> (state_r == sarseq_pkg::ST_IDLE) ##1 !o_mux_to_cap;
  endproperty
  a_abort_halt: assert property (p_abort_halt) else $error("Timing write did not halt.");

  property p_seq_start;
    @(posedge i_clk) disable iff (!i_rst_b)
      wr_seq |=> (state_r == sarseq_pkg::ST_SAMPLE) && (idx_r == 3'h0) && o_mux_to_cap;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("Sequence write did not start.");

  property p_flag_clear;
    @(posedge i_clk) disable iff (!i_rst_b)
      (wr_fire && (wr_tim || wr_seq) && (state_r != sarseq_pkg::ST_IDLE)) |=> (flags_r == 8'h00) && !sdone_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Abort left flags set.");

  property p_store;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_conv_end |=> (res_r[$past(idx_r)] == $past(final_val)) && flags_r[$past(idx_r)];
  endproperty
  a_store: assert property (p_store) else $error("Result or flag not stored.");

  property p_msb_first;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == sarseq_pkg::ST_CONVERT) && tick && (bit_r != 4'h0) && !wr_fire |=> bit_r == $past(bit_r) - 4'h1;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("Bit order broken.");

  property p_single_stop;
    @(posedge i_clk) disable iff (!i_rst_b)
      (s_conv_end and ((idx_r == last_idx) && !seq_r.repeat_sel)) |=>
        (state_r == sarseq_pkg::ST_IDLE) && sdone_r;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("Single sequence did not stop.");

  property p_sample_len;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_r == sarseq_pkg::ST_SAMPLE) ##1 (state_r == sarseq_pkg::ST_CONVERT) |->
        $past(samp_r) == samp_last;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("Sample period length wrong.");

  property p_phase_order;
    @(posedge i_clk) disable iff (!i_rst_b)
      $fell(o_mux_to_cap) && o_buf_to_array |-> !o_direct_to_array && (samp_r == sarseq_pkg::PH1_END);
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("Sample phase order wrong.");

endmodule : sarseq_top

// ---- test/sarseq_analog_model.sv ----
`timescale 1ns/1ns
module sarseq_analog_model (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [3:0]   i_mux_sel,
  input  wire logic         i_mux_en,
  input  wire logic [9:0]   i_dac_code,
  input  wire logic [159:0] i_levels,
  output logic              o_comp_higher
);
  // Compares the DAC code with the selected level; a disabled mux gives noise.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_comp_higher <= 1'h0;
    else if (i_mux_en)
      o_comp_higher <= i_dac_code > i_levels[i_mux_sel*10 +: 10];
    else
      o_comp_higher <= ~o_comp_higher;
  end
endmodule : sarseq_analog_model

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
  typedef struct {string nm; logic [33:0] v; logic [33:0] m;} sarseq_note_s;
  logic         clk, rst_b, awvalid, wvalid, bready, arvalid, rready, comp;
  logic         awready, wready, bvalid, arready, rvalid, mux_en, cap, bufa, dir;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, rdat;
  logic [1:0]   bresp, rresp;
  logic [3:0]   mux_sel;
  logic [9:0]   dac;
  logic [159:0] lv;
  sarseq_note_s q[$];
  int           num_errors, cmp_count, cap_n, buf_n, dir_n, exp_t, exp_d;
  bit           ph_on;

  sarseq_top uut (.i_clk(clk), .i_rst_b(rst_b), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .i_comp_higher(comp), .o_mux_sel(mux_sel),
    .o_mux_en(mux_en), .o_mux_to_cap(cap), .o_buf_to_array(bufa), .o_direct_to_array(dir),
    .o_dac_code(dac));

  sarseq_analog_model u_afe (.i_clk(clk), .i_rst_b(rst_b), .i_mux_sel(mux_sel),
    .i_mux_en(mux_en), .i_dac_code(dac), .i_levels(lv), .o_comp_higher(comp));

  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic check(string nm, logic [33:0] seen, logic [33:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("Counts: %0d mismatches, %0d comparisons", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // AXI write: both channels offered together, response awaited with bready high.
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    q.push_back('{$sformatf("bresp %h", a), {r, 32'h0}, {2'h3, 32'h0}});
    @(posedge clk);
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      if (bvalid)
      begin
        bready <= 1'h0;
        break;
      end
    end
  endtask : wr

  // AXI read; a zero mask leaves the answer unchecked.
  task automatic rd(logic [7:0] a, logic [33:0] v, logic [33:0] m);
    q.push_back('{$sformatf("read %h", a), v, m});
    @(posedge clk);
    arvalid <= 1'h1;
    araddr  <= a;
    rready  <= 1'h1;
    forever
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'h0;
      if (rvalid)
      begin
        rdat = rdata;
        rready <= 1'h0;
        break;
      end
    end
  endtask : rd

  // Takes the oldest note whenever a bus answer is handed over.
  always @(posedge clk)
    if ((bvalid && bready) || (rvalid && rready))
    begin
      sarseq_note_s n;
      n = q.pop_front();
      if (n.m != 0)
        check(n.nm, (bvalid ? {bresp, 32'h0} : {rresp, rdata}) & n.m, n.v & n.m);
    end

  // Measures how long each sample phase stays on.
  always @(posedge clk)
  begin
    if (!cap && cap_n > 0 && ph_on)
      check("cap_cycles", 34'(cap_n), 34'(2 * exp_t));
    if (!bufa && buf_n > 0 && ph_on)
      check("buf_cycles", 34'(buf_n), 34'(2 * exp_t));
    if (!dir && dir_n > 0 && ph_on)
      check("direct_cycles", 34'(dir_n), 34'(exp_d * exp_t));
    cap_n = cap ? cap_n + 1 : 0;
    buf_n = bufa ? buf_n + 1 : 0;
    dir_n = dir ? dir_n + 1 : 0;
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    int         m, n, nc, t;
    logic [9:0] lvl[16];
    logic [9:0] full;
    logic       ten, eig, rep, mul;
    logic [1:0] ext;
    logic [4:0] div;
    logic [3:0] base, ch;
    void'($urandom(32'h8FB83DC3));
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    lv = 160'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    rd(sarseq_pkg::OFS_TIMING, 34'h3, 34'h3FFFFFFFF);
    rd(sarseq_pkg::OFS_STATUS, 34'h0, 34'h3FFFFFFFF);
    rd(8'h0C, {sarseq_pkg::RESP_SLVERR, 32'h0}, 34'h3FFFFFFFF);
    wr(sarseq_pkg::OFS_STATUS, 32'h0, sarseq_pkg::RESP_SLVERR);
    for (m = 0; m < 8; m++)
    begin
      {rep, mul, eig} = m[2:0];
      ten = 1'($urandom);
      ext = 2'($urandom);
      div = (m == 0) ? 5'h0 : 5'($urandom_range(3, 1));
      for (n = 0; n < 16; n++)
        lvl[n] = 10'($urandom);
      lv <= {<<10{lvl}};
      base = mul ? (eig ? 4'h0 : 4'($urandom_range(4, 0))) :
             (eig ? 4'($urandom_range(15, 12)) : 4'($urandom_range(7, 0)));
      exp_t = 2 * ((div == 0 ? 1 : div) + 1);
      exp_d = 2 << ext;
      nc = eig ? 8 : 4;
      full = ten ? 10'h3FF : 10'h0FF;
      ph_on = 0;
      wr(sarseq_pkg::OFS_TIMING, {24'h0, ten, ext, div}, sarseq_pkg::RESP_OKAY);
      ph_on = 1;
      wr(sarseq_pkg::OFS_SEQUENCE, {25'h0, eig, rep, mul, base}, sarseq_pkg::RESP_OKAY);
      check("mux_sel", {30'h0, mux_sel}, {30'h0, base});
      check("mux_en", mux_en, 34'h1);
      check("cap_on", cap, 34'h1);
      t = 0;
      do
        rd(sarseq_pkg::OFS_STATUS, 34'h0, 34'h0);
      while (!rdat[15] && ++t < 3000);
      rd(sarseq_pkg::OFS_STATUS, {19'h1, rep, 3'(m), 3'h0, eig ? 8'hFF : 8'h0F}, 34'h3FFFFF8FF);
      if (rep)
      begin
        for (n = 0; n < 16; n++)
          lvl[n] = 10'($urandom);
        lv <= {<<10{lvl}};
        repeat (2 * nc * (4 + exp_d + (ten ? 10 : 8)) * exp_t + 50) @(posedge clk);
      end
      for (n = 0; n < nc; n++)
      begin
        ch = mul ? base + 4'(n) : base;
        rd(sarseq_pkg::OFS_RESULT + 8'(4 * n), {24'h0, lvl[ch] > full ? full : lvl[ch]},
           34'h3FFFFFFFF);
      end
      if (rep)
      begin
        ph_on = 0;
        wr(sarseq_pkg::OFS_SEQUENCE, {25'h0, eig, rep, mul, base}, sarseq_pkg::RESP_OKAY);
        rd(sarseq_pkg::OFS_STATUS, {19'h0, 1'h1, 3'(m), 11'h0}, 34'h3FFFFF8FF);
        wr(sarseq_pkg::OFS_TIMING, {24'h0, ten, ext, div}, sarseq_pkg::RESP_OKAY);
        repeat (4 * exp_t) @(posedge clk);
        rd(sarseq_pkg::OFS_STATUS, {20'h0, 3'(m), 11'h0}, 34'h3FFFFF8FF);
      end
    end
    wr(sarseq_pkg::OFS_SEQUENCE, 32'h9, sarseq_pkg::RESP_OKAY);
    check("mux_en_reserved", mux_en, 34'h0);
    ph_on = 0;
    wr(sarseq_pkg::OFS_TIMING, 32'h3, sarseq_pkg::RESP_OKAY);
    give_verdict();
  end
endmodule : tb
